// >>> verilog/dac_ctl_top.sv
// control port, mode latch, pin control, zero flags and analog mute status of a stereo dac
// assumes: pins are asynchronous; samples, strobe and clock status come from same-clock logic

`timescale 1ns/1ps
`default_nettype none

module dac_ctl_top (
  input  wire logic                             clk_in,
  input  wire logic                             rst_in,
  input  wire logic                             reset_pin_n_in,
  input  wire logic [1:0]                       mode_state_in,
  input  wire logic                             shared_pin21_in,
  input  wire logic                             shared_pin22_in,
  input  wire logic                             shared_pin23_in,
  input  wire logic                             shared_pin24_in,
  input  wire logic                             analog_mute_in,
  input  wire logic                             clock_halt_in,
  input  wire logic                             async_detect_in,
  input  wire logic                             sample_strobe_in,
  input  wire logic [dac_ctl_pkg::SAMPLE_W-1:0] left_sample_in,
  input  wire logic [dac_ctl_pkg::SAMPLE_W-1:0] right_sample_in,
  input  wire dac_ctl_pkg::word_len_e           word_len_in,
  output dac_ctl_pkg::iface_mode_e              iface_mode_out,
  output logic                                  auto_oversampling_out,
  output logic                                  twowire_enable_out,
  output logic [1:0]                            twowire_addr_out,
  output logic                                  deemphasis_enable_out,
  output logic                                  format_left_justified_out,
  output logic                                  reg_write_out,
  output dac_ctl_pkg::reg_write_s               reg_write_word_out,
  output dac_ctl_pkg::ctl_cfg_s                 cfg_out,
  output logic                                  dac_power_down_out,
  output logic                                  dac_output_center_out,
  output logic                                  analog_mute_status_out,
  output logic                                  zero_flag_one_out,
  output logic                                  zero_flags_valid_out,
  output logic                                  shared_pin_out,
  output logic                                  shared_pin_oe_out
);

  // pin synchroniser: stage one feeds only stage two
  localparam int PIN_W = 8;

  logic [PIN_W-1:0] pin_meta;
  logic [PIN_W-1:0] pin_sync;
  logic             sclk_prev;
  logic [1:0]       mode_s;
  logic             rst_pin_n_s;
  logic             ctl_serial_data_in;
  logic             ctl_serial_clock;
  logic             ctl_select_n;
  logic             addr_bit_five;
  logic             analog_mute_s;
  logic             int_rst;
  logic             latch_pending;
  logic             spi_mode;
  logic             parallel_mode;
  logic             sclk_rise;
  logic             rx_wr;
  logic             zero_left;
  logic             zero_right;
  logic             comb_b;
  logic             flag_one_raw;
  logic             flag_two_raw;
  logic             flag_one;
  logic             flag_two;
  logic             internal_mute;
  logic             pd_request;
  logic             zero_valid;
  logic [1:0]       addr_hi;
  dac_ctl_pkg::reg_write_s rx_word;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pin_meta  <= '0;
      pin_sync  <= '0;
      sclk_prev <= 1'b0;
    end else begin
      pin_meta  <= {reset_pin_n_in, mode_state_in, shared_pin21_in, shared_pin22_in,
                    shared_pin23_in, shared_pin24_in, analog_mute_in};
      pin_sync  <= pin_meta;
      sclk_prev <= ctl_serial_clock;
    end
  end

  assign rst_pin_n_s        = pin_sync[7];
  assign mode_s             = pin_sync[6:5];
  assign ctl_serial_data_in = pin_sync[4];
  assign ctl_serial_clock   = pin_sync[3];
  assign ctl_select_n       = pin_sync[2];
  assign addr_bit_five      = pin_sync[1];
  assign analog_mute_s      = pin_sync[0];

  // power-on or a low reset pin; registers and power state follow it
  assign int_rst = rst_in || !rst_pin_n_s;

  // mode latch: caught once on the first cycle after reset release
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      iface_mode_out <= dac_ctl_pkg::MODE_RESET;
      latch_pending  <= 1'b1;
    end else if (int_rst) begin
      latch_pending  <= 1'b1;
    end else if (latch_pending) begin
      iface_mode_out <= dac_ctl_pkg::iface_mode_e'(mode_s);
      latch_pending  <= 1'b0;
    end
  end

  assign parallel_mode = (iface_mode_out == dac_ctl_pkg::MODE_PARALLEL) && !latch_pending;
  assign spi_mode      = iface_mode_out[1] && !latch_pending;
  assign addr_hi       = {iface_mode_out[0], addr_bit_five};
  assign sclk_rise     = ctl_serial_clock && !sclk_prev;

  // pin function per latched mode; reserved inputs in parallel mode are ignored
  always_ff @(posedge clk_in) begin
    if (int_rst || latch_pending) begin
      auto_oversampling_out     <= 1'b0;
      twowire_enable_out        <= 1'b0;
      twowire_addr_out          <= 2'b00;
      deemphasis_enable_out     <= 1'b0;
      format_left_justified_out <= 1'b0;
    end else begin
      auto_oversampling_out     <= parallel_mode;
      twowire_enable_out        <= (iface_mode_out == dac_ctl_pkg::MODE_TWOWIRE);
      twowire_addr_out          <= (iface_mode_out == dac_ctl_pkg::MODE_TWOWIRE) ?
                                   {addr_bit_five, ctl_select_n} : 2'b00;
      deemphasis_enable_out     <= parallel_mode && ctl_serial_data_in;
      format_left_justified_out <= parallel_mode && ctl_serial_clock;
    end
  end

  // serial port runs on sampled pin edges only, no audio clock involved
  ctl_spi_rx u_rx (
    .clk_in       (clk_in),
    .rst_in       (int_rst),
    .enable_in    (spi_mode),
    .sel_n_in     (ctl_select_n),
    .sclk_rise_in (sclk_rise),
    .sdi_in       (ctl_serial_data_in),
    .addr_hi_in   (addr_hi),
    .wr_out       (rx_wr),
    .wr_word_out  (rx_word)
  );

  assign reg_write_out      = rx_wr;
  assign reg_write_word_out = rx_word;

  // control bits held locally; full map lives outside this block
  always_ff @(posedge clk_in) begin
    if (int_rst) begin
      cfg_out <= dac_ctl_pkg::CFG_RESET;
    end else if (rx_wr && rx_word.index == dac_ctl_pkg::REG_ZERO_CTL) begin
      cfg_out.zero_combination_select <= rx_word.data[dac_ctl_pkg::ZC_COMB_BIT];
      cfg_out.zero_polarity_invert    <= rx_word.data[dac_ctl_pkg::ZC_POL_BIT];
      cfg_out.shared_pin_select       <= rx_word.data[dac_ctl_pkg::ZC_SEL_BIT];
    end else if (rx_wr && rx_word.index == dac_ctl_pkg::REG_DAC_CTL) begin
      cfg_out.dac_operation_disable   <= rx_word.data[dac_ctl_pkg::DC_OPDIS_BIT];
      cfg_out.dac_power_save          <= rx_word.data[dac_ctl_pkg::DC_PSAVE_BIT];
    end
  end

  zero_detect u_zero_left (
    .clk_in      (clk_in),
    .rst_in      (int_rst),
    .strobe_in   (sample_strobe_in),
    .sample_in   (left_sample_in),
    .word_len_in (word_len_in),
    .zero_out    (zero_left)
  );

  zero_detect u_zero_right (
    .clk_in      (clk_in),
    .rst_in      (int_rst),
    .strobe_in   (sample_strobe_in),
    .sample_in   (right_sample_in),
    .word_len_in (word_len_in),
    .zero_out    (zero_right)
  );

  assign zero_valid   = (word_len_in != dac_ctl_pkg::WL_32);
  assign comb_b       = cfg_out.zero_combination_select && !parallel_mode;
  assign flag_one_raw = comb_b ? (zero_left || zero_right) : zero_left;
  assign flag_two_raw = comb_b ? (zero_left && zero_right) : zero_right;
  assign flag_one     = flag_one_raw ^ cfg_out.zero_polarity_invert;
  assign flag_two     = flag_two_raw ^ cfg_out.zero_polarity_invert;

  // internal mute causes; both channels zero counts as zero detect
  assign internal_mute = clock_halt_in || async_detect_in ||
                         (zero_left && zero_right) || cfg_out.dac_operation_disable;
  // power-save field is active low: low requests power-down
  assign pd_request    = cfg_out.dac_operation_disable || !cfg_out.dac_power_save;

  always_ff @(posedge clk_in) begin
    if (int_rst) begin
      dac_power_down_out     <= 1'b1;
      dac_output_center_out  <= 1'b1;
      analog_mute_status_out <= 1'b1;
    end else begin
      dac_power_down_out     <= analog_mute_s && pd_request;
      dac_output_center_out  <= !analog_mute_s || internal_mute || pd_request;
      analog_mute_status_out <= !internal_mute;
    end
  end

  // shared pin: flag two driven both ways, mute status as open drain pulling low
  always_ff @(posedge clk_in) begin
    if (int_rst) begin
      zero_flag_one_out    <= 1'b0;
      zero_flags_valid_out <= 1'b0;
      shared_pin_out       <= 1'b0;
      shared_pin_oe_out    <= 1'b1;
    end else begin
      zero_flag_one_out    <= flag_one;
      zero_flags_valid_out <= zero_valid;
      if (cfg_out.shared_pin_select) begin
        shared_pin_out    <= 1'b0;
        shared_pin_oe_out <= internal_mute;
      end else begin
        shared_pin_out    <= flag_two;
        shared_pin_oe_out <= 1'b1;
      end
    end
  end

  AST_MUTE_CENTER: assert property (@(posedge clk_in) disable iff (int_rst)
    !analog_mute_s |=> dac_output_center_out)
    else $error("mute input low did not center the output");

  AST_MUTE_PRIORITY: assert property (@(posedge clk_in) disable iff (int_rst)
    (!analog_mute_s && pd_request) |=> !dac_power_down_out && dac_output_center_out)
    else $error("power-down not overridden by mute input");

  AST_STATUS_LOW: assert property (@(posedge clk_in) disable iff (int_rst)
    (clock_halt_in || async_detect_in || cfg_out.dac_operation_disable) |=> !analog_mute_status_out)
    else $error("mute status not low during internal mute");

  AST_SHARED_DEFAULT: assert property (@(posedge clk_in) disable iff (rst_in)
    (int_rst ##1 !int_rst) |-> shared_pin_oe_out && shared_pin_out == 1'b0 && !cfg_out.shared_pin_select)
    else $error("shared pin not carrying flag two after reset");

  AST_SHARED_FLAG: assert property (@(posedge clk_in) disable iff (int_rst)
    !cfg_out.shared_pin_select |=> shared_pin_oe_out && shared_pin_out == $past(flag_two))
    else $error("shared pin does not follow flag two");

  AST_MODE_HOLD: assert property (@(posedge clk_in) disable iff (int_rst)
    (!latch_pending && $past(!latch_pending)) |-> $stable(iface_mode_out))
    else $error("mode changed outside reset release");

  AST_PAR_COMB_A: assert property (@(posedge clk_in) disable iff (int_rst)
    parallel_mode |=> zero_flag_one_out == $past(zero_left ^ cfg_out.zero_polarity_invert))
    else $error("parallel mode flag one not tied to left channel");

  AST_POWER_DOWN_RESET: assert property (@(posedge clk_in) disable iff (rst_in)
    !rst_pin_n_s |=> dac_power_down_out && cfg_out == dac_ctl_pkg::CFG_RESET)
    else $error("reset pin did not force power-down and defaults");

  AST_INVALID_32: assert property (@(posedge clk_in) disable iff (int_rst)
    (word_len_in == dac_ctl_pkg::WL_32)[*2] |=> !zero_flags_valid_out && !zero_left && !zero_right)
    else $error("zero flags valid with 32-bit words");

  AST_COMB_B: assert property (@(posedge clk_in) disable iff (int_rst)
    comb_b |=> zero_flag_one_out == $past((zero_left || zero_right) ^ cfg_out.zero_polarity_invert))
    else $error("combination b flag one wrong");

endmodule

`default_nettype wire

// >>> verilog/dac_ctl_pkg.sv
// package: shared types and constants for the dac control and zero flag logic
// assumes: one 125 MHz clock, 24-bit left-aligned samples from the audio path

package dac_ctl_pkg;

  typedef enum logic [1:0] {
    MODE_TWOWIRE    = 2'b00,
    MODE_PARALLEL   = 2'b01,
    MODE_SPI_ADDR_BIT_SIX_0 = 2'b10,
    MODE_SPI_ADDR_BIT_SIX_1 = 2'b11
  } iface_mode_e;

  typedef enum logic [1:0] {
    WL_16 = 2'b00,
    WL_20 = 2'b01,
    WL_24 = 2'b10,
    WL_32 = 2'b11
  } word_len_e;

  typedef enum logic [1:0] {
    RX_WORD = 2'b00,
    RX_BYTE = 2'b01,
    RX_DONE = 2'b10
  } rx_state_e;

  typedef struct packed {
    logic zero_combination_select;
    logic zero_polarity_invert;
    logic shared_pin_select;
    logic dac_operation_disable;
    logic dac_power_save;
  } ctl_cfg_s;

  typedef struct packed {
    logic [4:0] index;
    logic [7:0] data;
  } reg_write_s;

  localparam int          SAMPLE_W         = 24;
  localparam int          ZERO_RUN_PERIODS = 1024;
  localparam int          ZERO_CNT_W       = 11;
  localparam logic [3:0]  WORD_LAST_BIT    = 4'hf;
  localparam logic [3:0]  BYTE_LAST_BIT    = 4'h7;
  localparam logic [3:0]  MULTI_MAX_BYTES  = 4'h9;
  localparam logic [4:0]  REG_ZERO_CTL     = 5'h16;
  localparam logic [4:0]  REG_DAC_CTL      = 5'h12;
  localparam int          ZC_COMB_BIT      = 0;
  localparam int          ZC_POL_BIT       = 1;
  localparam int          ZC_SEL_BIT       = 2;
  localparam int          DC_OPDIS_BIT     = 7;
  localparam int          DC_PSAVE_BIT     = 6;
  localparam ctl_cfg_s    CFG_RESET        = ctl_cfg_s'(5'h01);
  localparam iface_mode_e MODE_RESET       = MODE_TWOWIRE;

  function automatic logic [SAMPLE_W-1:0] sample_mask(input word_len_e wl);
    case (wl)
      WL_16:   sample_mask = 24'hffff00;
      WL_20:   sample_mask = 24'hfffff0;
      WL_24:   sample_mask = 24'hffffff;
      default: sample_mask = 24'h000000;
    endcase
  endfunction

endpackage

// >>> verilog/zero_detect.sv
// zero data detector for one channel
// assumes: strobe_in pulses once per word-clock period, same clock domain

`timescale 1ns/1ps
`default_nettype none

module zero_detect (
  input  wire logic                             clk_in,
  input  wire logic                             rst_in,
  input  wire logic                             strobe_in,
  input  wire logic [dac_ctl_pkg::SAMPLE_W-1:0] sample_in,
  input  wire dac_ctl_pkg::word_len_e           word_len_in,
  output logic                                  zero_out
);

  logic [dac_ctl_pkg::ZERO_CNT_W-1:0] run;
  logic                               bits_set;
  logic                               supported;

  assign bits_set  = |(sample_in & dac_ctl_pkg::sample_mask(word_len_in));
  assign supported = (word_len_in != dac_ctl_pkg::WL_32);

  always_ff @(posedge clk_in) begin
    if (rst_in || !supported) begin
      run      <= '0;
      zero_out <= 1'b0;
    end else if (strobe_in) begin
      if (bits_set) begin
        run      <= '0;
        zero_out <= 1'b0;
      end else if (run == dac_ctl_pkg::ZERO_CNT_W'(dac_ctl_pkg::ZERO_RUN_PERIODS - 1)) begin
        zero_out <= 1'b1;
      end else begin
        run <= run + 1'b1;
      end
    end
  end

  AST_ZERO_CLEAR: assert property (@(posedge clk_in) disable iff (rst_in)
    (strobe_in && bits_set) |=> !zero_out)
    else $error("zero flag not cleared by nonzero sample");

  AST_ZERO_SET: assert property (@(posedge clk_in) disable iff (rst_in)
    (supported && strobe_in && !bits_set && !zero_out &&
     run == dac_ctl_pkg::ZERO_CNT_W'(dac_ctl_pkg::ZERO_RUN_PERIODS - 1)) |=> zero_out)
    else $error("zero flag not set after full zero run");

  AST_ZERO_EARLY: assert property (@(posedge clk_in) disable iff (rst_in)
    ($rose(zero_out)) |-> $past(run) == dac_ctl_pkg::ZERO_CNT_W'(dac_ctl_pkg::ZERO_RUN_PERIODS - 1))
    else $error("zero flag set before full zero run");

endmodule

`default_nettype wire

// >>> verilog/ctl_spi_rx.sv
// three-wire control port receiver: 16-bit word then up to nine data bytes
// assumes: inputs already synchronised; sclk_rise_in is a one-cycle pulse

`timescale 1ns/1ps
`default_nettype none

module ctl_spi_rx (
  input  wire logic                    clk_in,
  input  wire logic                    rst_in,
  input  wire logic                    enable_in,
  input  wire logic                    sel_n_in,
  input  wire logic                    sclk_rise_in,
  input  wire logic                    sdi_in,
  input  wire logic [1:0]              addr_hi_in,
  output logic                         wr_out,
  output dac_ctl_pkg::reg_write_s      wr_word_out
);

  dac_ctl_pkg::rx_state_e  state;
  dac_ctl_pkg::reg_write_s pend;
  logic [14:0]             shift;
  logic [3:0]              bit_cnt;
  logic [3:0]              byte_cnt;
  logic                    pending;
  logic [15:0]             word;

  assign word = {shift, sdi_in};

  always_ff @(posedge clk_in) begin
    if (rst_in || !enable_in) begin
      state       <= dac_ctl_pkg::RX_WORD;
      shift       <= '0;
      bit_cnt     <= '0;
      byte_cnt    <= '0;
      pending     <= 1'b0;
      pend        <= '0;
      wr_out      <= 1'b0;
      wr_word_out <= '0;
    end else begin
      wr_out <= 1'b0;
      if (sel_n_in) begin
        // select high ends the frame and latches the held write
        state    <= dac_ctl_pkg::RX_WORD;
        bit_cnt  <= '0;
        byte_cnt <= '0;
        pending  <= 1'b0;
        if (pending) begin
          wr_out      <= 1'b1;
          wr_word_out <= pend;
        end
      end else if (sclk_rise_in) begin
        shift   <= word[14:0];
        bit_cnt <= bit_cnt + 1'b1;
        case (state)
          dac_ctl_pkg::RX_WORD: begin
            if (bit_cnt == dac_ctl_pkg::WORD_LAST_BIT) begin
              pending    <= !word[15] && (word[14:13] == addr_hi_in);
              pend.index <= word[12:8];
              pend.data  <= word[7:0];
              bit_cnt    <= '0;
              state      <= dac_ctl_pkg::RX_BYTE;
            end
          end
          dac_ctl_pkg::RX_BYTE: begin
            if (bit_cnt == dac_ctl_pkg::BYTE_LAST_BIT) begin
              bit_cnt <= '0;
              if (byte_cnt == dac_ctl_pkg::MULTI_MAX_BYTES - 1'b1) begin
                state <= dac_ctl_pkg::RX_DONE;
              end
              byte_cnt    <= byte_cnt + 1'b1;
              wr_out      <= pending;
              wr_word_out <= pend;
              pend.index  <= pend.index + 1'b1;
              pend.data   <= word[7:0];
            end
          end
          dac_ctl_pkg::RX_DONE: begin
            bit_cnt <= '0;
          end
          default: begin
            state <= dac_ctl_pkg::RX_WORD;
          end
        endcase
      end
    end
  end

  AST_RX_LATCH: assert property (@(posedge clk_in) disable iff (rst_in || !enable_in)
    (sel_n_in && pending) |=> (wr_out && wr_word_out == $past(pend)))
    else $error("held write not latched on select rise");

  AST_RX_INC: assert property (@(posedge clk_in) disable iff (rst_in || !enable_in)
    (!sel_n_in && sclk_rise_in && state == dac_ctl_pkg::RX_BYTE && bit_cnt == dac_ctl_pkg::BYTE_LAST_BIT &&
     pending) |=> (wr_out && pend.index == $past(pend.index) + 5'h01))
    else $error("multiple write address did not advance");

  AST_RX_NOMATCH: assert property (@(posedge clk_in) disable iff (rst_in || !enable_in)
    (!sel_n_in && sclk_rise_in && state == dac_ctl_pkg::RX_WORD && bit_cnt == dac_ctl_pkg::WORD_LAST_BIT &&
     (word[15] || word[14:13] != addr_hi_in)) |=> !pending)
    else $error("write accepted for foreign address");

endmodule

`default_nettype wire

// >>> test/ctl_host.sv
// host model for the three-wire control port
// assumes: bench clock paces every pin change on its falling edge
`timescale 1ns/1ps
`default_nettype none
module ctl_host (
  input  wire logic clk_in,
  output logic      sdi_out,
  output logic      sclk_out,
  output logic      sel_n_out
);
  initial begin
    sdi_out   = 1'h1;
    sclk_out  = 1'h0;
    sel_n_out = 1'h1;
  end
  // parallel mode reuses data and clock lines as static level pins
  task automatic pins(input logic d, input logic c);
    sdi_out  = d;
    sclk_out = c;
  endtask
  task automatic half();
    repeat (10) @(negedge clk_in);
  endtask
  // n bits msb first from the top of w; clock idles low, 160 ns per bit
  task automatic frame(input logic [47:0] w, input int n);
    sel_n_out = 1'h0;
    for (int i = 0; i < n; i++) begin
      sdi_out = w[47-i];
      half();
      sclk_out = 1'h1;
      half();
      sclk_out = 1'h0;
    end
    half();
    sel_n_out = 1'h1;
    sdi_out   = ~sdi_out; // released line must not look like a held bit
    half();
  endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// bench for the dac control top: mode latch, zero flags, serial writes, mute
// assumes: ctl_host drives the serial pins; other inputs change on falling clk
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                     clk_in, rst_in, analog_mute_in, sample_strobe_in;
  logic [1:0]               mode_state_in;
  logic [23:0]              left_sample_in;
  dac_ctl_pkg::word_len_e   word_len_in;
  dac_ctl_pkg::iface_mode_e iface_mode;
  dac_ctl_pkg::ctl_cfg_s    cfg;
  logic                     sdi, sclk, sel_n, pd, center, mute_st, flag1, valid, shared;
  logic                     reset_pin_n, halt, wr, auto_os, tw_en, deemph, fmt_lj, oe;
  logic [1:0]               tw_addr;
  logic [12:0]              wr_word;
  logic [15:0]              last_word = 16'h0000;
  int                       writes = 0;
  int                       mismatches = 0;
  int                       checks = 0;
  int                       cycles = 0;
  ctl_host u_ctl_host (.clk_in, .sdi_out(sdi), .sclk_out(sclk), .sel_n_out(sel_n));
  // right channel held at zero: flag two then only needs strobes to count
  dac_ctl_top u_dac_ctl_top (
    .clk_in, .rst_in, .reset_pin_n_in(reset_pin_n), .mode_state_in,
    .shared_pin21_in(sdi), .shared_pin22_in(sclk), .shared_pin23_in(sel_n), .shared_pin24_in(1'h0),
    .analog_mute_in, .clock_halt_in(halt), .async_detect_in(1'h0), .sample_strobe_in,
    .left_sample_in, .right_sample_in(24'h000000), .word_len_in,
    .iface_mode_out(iface_mode), .auto_oversampling_out(auto_os), .twowire_enable_out(tw_en),
    .twowire_addr_out(tw_addr), .deemphasis_enable_out(deemph), .format_left_justified_out(fmt_lj),
    .reg_write_out(wr), .reg_write_word_out(wr_word),
    .cfg_out(cfg), .dac_power_down_out(pd), .dac_output_center_out(center),
    .analog_mute_status_out(mute_st), .zero_flag_one_out(flag1), .zero_flags_valid_out(valid),
    .shared_pin_out(shared), .shared_pin_oe_out(oe)
  );
  // write pulse lasts one cycle, so count it at the clock instead of polling
  always @(posedge clk_in) begin
    if (wr) begin
      writes    <= writes + 1;
      last_word <= {3'h0, wr_word};
    end
  end
  initial begin
    clk_in = 1'h0;
    forever #4 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      mismatches = mismatches + 1;
      end_sim();
    end
  end
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      mismatches = mismatches + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge clk_in);
  endtask
  // reset pin pulse with a new mode strap; mode must be caught at release
  task automatic pin_rst(input logic [1:0] m);
    reset_pin_n   = 1'h0;
    mode_state_in = m;
    wt(4);
    chk(pd, 1'h1);
    chk(cfg, 5'h01);
    reset_pin_n = 1'h1;
    wt(6);
    chk(iface_mode, m);
  endtask
  task automatic zs(input int n, input logic [23:0] l);
    repeat (n) begin
      @(negedge clk_in);
      sample_strobe_in = 1'h1;
      left_sample_in   = l;
      @(negedge clk_in);
      sample_strobe_in = 1'h0;
    end
  endtask
  initial begin
    rst_in           = 1'h1;
    reset_pin_n      = 1'h1;
    halt             = 1'h0;
    analog_mute_in   = 1'h1;
    sample_strobe_in = 1'h0;
    mode_state_in    = 2'h2;
    left_sample_in   = 24'h000100;
    word_len_in      = dac_ctl_pkg::WL_16;
    wt(2);
    rst_in = 1'h0;
    wt(6);
    chk(iface_mode, 2'h2);
    chk(cfg, 5'h01);
    mode_state_in = 2'h0;
    wt(6);
    chk(iface_mode, 2'h2);
    chk(valid, 1'h1);
    // low byte is below a 16-bit word, so it must read as zero
    zs(1, 24'h000100);
    zs(1023, 24'h0000ff);
    wt(3);
    chk(flag1, 1'h0);
    zs(1, 24'h0000ff);
    wt(3);
    chk(flag1, 1'h1);
    chk(shared, 1'h1);
    zs(1, 24'h000100);
    wt(3);
    chk(flag1, 1'h0);
    word_len_in = dac_ctl_pkg::WL_32;
    wt(3);
    chk(valid, 1'h0);
    word_len_in = dac_ctl_pkg::WL_24;
    u_ctl_host.frame({1'h0, 2'h0, 5'h12, 8'h80, 8'h00, 8'h00, 8'h00, 8'h01}, 48);
    chk(cfg, 5'h12);
    chk(16'(writes), 16'h0005);
    chk(last_word, 16'h1601);
    u_ctl_host.frame({1'h0, 2'h1, 5'h16, 8'h06, 32'h0}, 16);
    chk(cfg, 5'h12);
    chk(16'(writes), 16'h0005);
    u_ctl_host.frame({1'h0, 2'h0, 5'h16, 8'h06, 32'h0}, 16);
    chk(cfg, 5'h0e);
    chk(16'(writes), 16'h0006);
    chk(last_word, 16'h1606);
    chk(flag1, 1'h1);
    chk(pd, 1'h1);
    chk(mute_st, 1'h0);
    chk(shared, 1'h0);
    chk(oe, 1'h1);
    analog_mute_in = 1'h0;
    wt(5);
    chk(center, 1'h1);
    chk(pd, 1'h0);
    analog_mute_in = 1'h1;
    pin_rst(2'h1);
    chk(auto_os, 1'h1);
    chk(tw_en, 1'h0);
    u_ctl_host.pins(1'h0, 1'h1);
    wt(5);
    chk(deemph, 1'h0);
    chk(fmt_lj, 1'h1);
    u_ctl_host.pins(1'h1, 1'h0);
    wt(5);
    chk(deemph, 1'h1);
    chk(fmt_lj, 1'h0);
    // port pins are repurposed here, so a frame must not write
    u_ctl_host.frame({1'h0, 2'h0, 5'h16, 8'h07, 32'h0}, 16);
    chk(cfg, 5'h01);
    chk(16'(writes), 16'h0006);
    pin_rst(2'h0);
    chk(tw_en, 1'h1);
    chk(tw_addr, 2'h1);
    chk(mute_st, 1'h1);
    halt = 1'h1;
    wt(3);
    chk(mute_st, 1'h0);
    end_sim();
  end
endmodule
`default_nettype wire
